// ---- rtl/dwdt_top.sv ----
// dual watchdog top: reset release, window watchdog, independent core
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - start code enables independent count, zero resets
// - refresh code reloads independent counter
// - unlock code opens prescale and reload writes
// - any other key value relocks them
// - refresh code also relocks them
// - auto-start strap runs counter after reset
// - debug halt freezes counter when selected
// - prescaler, 12-bit counter, 12-bit reload
// - runs from own low-speed tick
// - timeouts scale 0.125ms to 32768ms, doubling
// - 7-bit window counter, divided bus clock
// - enabled window resets on 0x40 to 0x3F
// - enabled early reload above window resets
// - window disabled at reset, software enables
// - window counter keeps counting while disabled
// - early warning raised as count reaches 0x40
// - writing zero clears early warning flag
// - timeout is 4096 times 2^div times cnt[5:0]+1
// - prescale code divides 4 to 256
// - reload resets to all ones, flag-gated writes
// - key register always reads zero
module dwdt_top #(
    parameter int WIN_BASE_DIV = dwdt_pkg::WIN_BASE_DIV
) (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // independent watchdog side
    input  wire logic        lsi_tick,
    input  wire logic        auto_start,
    input  wire logic        dbg_halt,
    input  wire logic        debug_freeze_reg,
    input  wire logic        indep_key_wr,
    input  wire logic [15:0] indep_key_data,
    input  wire logic        indep_prescale_wr,
    input  wire logic [2:0]  indep_prescale_data,
    input  wire logic        indep_reload_wr,
    input  wire logic [11:0] indep_reload_data,
    input  wire logic        indep_rst_ack,
    output logic [15:0]      indep_key_rdata,
    output logic [2:0]       indep_prescale_reg,
    output logic [11:0]      indep_reload_reg,
    output logic             prescale_update_flag,
    output logic             reload_update_flag,
    output logic             indep_unlocked,
    output logic             indep_running,
    output logic [11:0]      indep_count,
    output logic             indep_rst_req,
    // window watchdog side
    input  wire logic        window_control_wr,
    input  wire logic        window_enable_bit,
    input  wire logic [6:0]  window_count_data,
    input  wire logic        window_config_wr,
    input  wire logic [6:0]  window_value_data,
    input  wire logic [1:0]  window_timebase_div,
    input  wire logic        early_warning_int_enable,
    input  wire logic        window_status_wr,
    input  wire logic        window_status_data,
    input  wire logic        window_rst_ack,
    output logic             window_enabled,
    output logic [6:0]       window_count,
    output logic [6:0]       window_value,
    output logic [1:0]       window_div,
    output logic             window_ewi_enabled,
    output logic             window_status_reg,
    output logic             window_irq,
    output logic             window_rst_req
);
    localparam int PRE_W = $clog2(WIN_BASE_DIV * dwdt_pkg::WIN_DIV_STEPS);

    if (WIN_BASE_DIV < 1 || (WIN_BASE_DIV & (WIN_BASE_DIV - 1)) != 0) begin : g_chk
        $error("WIN_BASE_DIV must be a power of two");
    end

    // ==============================================================
    // reset release: async assert, two-flop synchronous release
    logic rst_sync1_reg, rst_n;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync1_reg <= 1'b0;
            rst_n         <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_n         <= rst_sync1_reg;
        end
    end

    // ==============================================================
    // independent watchdog
    dwdt_indep u_indep (
        .sys_clk              (sys_clk),
        .rst_n                (rst_n),
        .lsi_tick             (lsi_tick),
        .auto_start           (auto_start),
        .dbg_halt             (dbg_halt),
        .dbg_freeze           (debug_freeze_reg),
        .key_wr               (indep_key_wr),
        .key_data             (indep_key_data),
        .psc_wr               (indep_prescale_wr),
        .psc_data             (indep_prescale_data),
        .rld_wr               (indep_reload_wr),
        .rld_data             (indep_reload_data),
        .rst_ack              (indep_rst_ack),
        .indep_prescale_reg   (indep_prescale_reg),
        .indep_reload_reg     (indep_reload_reg),
        .prescale_update_flag (prescale_update_flag),
        .reload_update_flag   (reload_update_flag),
        .unlocked             (indep_unlocked),
        .running              (indep_running),
        .count                (indep_count),
        .rst_req              (indep_rst_req)
    );

    // write-only key: reads never reveal the last code
    assign indep_key_rdata = dwdt_pkg::KEY_RDATA;

    // ==============================================================
    // window watchdog timebase
    // last prescaler count for a code: base times two to the code, less one
    function automatic logic [PRE_W-1:0] win_last(input logic [1:0] code);
        win_last = PRE_W'((WIN_BASE_DIV << code) - 1);
    endfunction

    logic [PRE_W-1:0] pre_reg, pre_next;
    logic             win_tick;

    // the bus clock is sys_clk itself, so no crossing is needed
    assign win_tick = pre_reg == win_last(window_div);

    always_comb begin
        pre_next = win_tick ? '0 : PRE_W'(pre_reg + 1'b1);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            pre_reg <= '0;
        else
            pre_reg <= pre_next;
    end

    // ==============================================================
    // window watchdog control, counter, flag and reset request
    logic       en_reg, en_next;
    logic [6:0] cnt_reg, cnt_next, val_reg, val_next;
    logic [1:0] div_reg, div_next;
    logic       ewie_reg, ewie_next, flag_reg, flag_next;
    logic       req_reg, req_next, under, early, warn;

    // underflow only matters while enabled; counting never stops
    assign under = en_reg && win_tick && !window_control_wr
                   && cnt_reg == dwdt_pkg::WIN_LOW_LIMIT;
    // whole 7-bit compare so the window covers the top half too
    assign early = en_reg && window_control_wr && cnt_reg > val_reg;
    assign warn  = win_tick && !window_control_wr
                   && cnt_reg == dwdt_pkg::WIN_WARN_PRE;

    always_comb begin
        en_next   = en_reg;
        cnt_next  = cnt_reg;
        val_next  = val_reg;
        div_next  = div_reg;
        ewie_next = ewie_reg;
        flag_next = flag_reg;
        // enable can only be set; it falls only with system reset
        if (window_control_wr && window_enable_bit)
            en_next = 1'b1;
        if (window_control_wr)
            cnt_next = window_count_data;
        else if (win_tick)
            cnt_next = 7'(cnt_reg - 7'h01);
        if (window_config_wr) begin
            val_next  = window_value_data;
            div_next  = window_timebase_div;
            ewie_next = early_warning_int_enable;
        end
        // writing zero clears; a new warning in the same cycle wins
        if (window_status_wr && !window_status_data)
            flag_next = 1'b0;
        if (warn)
            flag_next = 1'b1;
        req_next = under || early || (req_reg && !window_rst_ack);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_reg   <= 1'b0;
            cnt_reg  <= dwdt_pkg::WIN_CNT_RST;
            val_reg  <= dwdt_pkg::WIN_VALUE_RST;
            div_reg  <= dwdt_pkg::WIN_DIV_RST;
            ewie_reg <= 1'b0;
            flag_reg <= 1'b0;
            req_reg  <= 1'b0;
        end else begin
            en_reg   <= en_next;
            cnt_reg  <= cnt_next;
            val_reg  <= val_next;
            div_reg  <= div_next;
            ewie_reg <= ewie_next;
            flag_reg <= flag_next;
            req_reg  <= req_next;
        end
    end

    // outputs straight from registers; irq is a simple gate
    assign window_enabled     = en_reg;
    assign window_count       = cnt_reg;
    assign window_value       = val_reg;
    assign window_div         = div_reg;
    assign window_ewi_enabled = ewie_reg;
    assign window_status_reg  = flag_reg;
    assign window_irq         = flag_reg && ewie_reg;
    assign window_rst_req     = req_reg;

    // ==============================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_WIN_UNDERFLOW: assert property (under |=> window_rst_req)
        else $error("no reset on window underflow");
    AST_WIN_EARLY: assert property (
        en_reg && window_control_wr && cnt_reg > val_reg |=> window_rst_req)
        else $error("no reset on early reload");
    AST_WIN_ENABLE: assert property (
        !window_enabled && !(window_control_wr && window_enable_bit) |=> !window_enabled)
        else $error("window enabled without software");
    AST_WIN_FREE: assert property (
        win_tick && !window_control_wr |=> window_count == 7'($past(window_count) - 7'h01))
        else $error("window counter did not decrement");
    AST_WIN_WARN: assert property (
        warn && ewie_reg && !window_config_wr |=> window_irq && window_count == 7'h40)
        else $error("early warning missed");
    AST_WIN_CLEAR: assert property (
        window_status_wr && !window_status_data && !warn |=> !window_status_reg)
        else $error("warning flag not cleared");
    AST_WIN_SPACING: assert property (win_tick |=> (!win_tick)[*8])
        else $error("window ticks too close");
    AST_WIN_HOLD: assert property (window_rst_req && !window_rst_ack |=> window_rst_req)
        else $error("window reset request dropped");
    AST_IND_HOLD: assert property (indep_rst_req && !indep_rst_ack |=> indep_rst_req)
        else $error("independent reset request dropped");
    AST_KEY_READ: assert property (indep_key_rdata == 16'h0000)
        else $error("key read not zero");

    COV_WIN_UNDER: cover property (under ##1 window_rst_req);
    COV_WIN_EARLY: cover property (early ##1 window_rst_req);
    COV_WIN_WARN:  cover property (warn ##1 window_irq);
    COV_IND_REQ:   cover property (indep_running ##[1:1000] indep_rst_req);
endmodule

`default_nettype wire

// ---- rtl/dwdt_indep.sv ----
// constants package and the independent watchdog core
`timescale 1ns/1ps
`default_nettype none

package dwdt_pkg;
    // ==============================================================
    // key codes and reset values
    localparam logic [15:0] KEY_UNLOCK   = 16'h5555;
    localparam logic [15:0] KEY_REFRESH  = 16'haaaa;
    localparam logic [15:0] KEY_START    = 16'hcccc;
    localparam logic [15:0] KEY_RDATA    = 16'h0000;
    localparam logic [11:0] RELOAD_RST   = 12'hfff;
    localparam logic [2:0]  PRESCALE_RST = 3'h0;
    localparam logic [11:0] IND_CNT_ZERO = 12'h000;
    // ==============================================================
    // window watchdog values
    localparam logic [6:0]  WIN_CNT_RST   = 7'h7f;
    localparam logic [6:0]  WIN_VALUE_RST = 7'h7f;
    localparam logic [1:0]  WIN_DIV_RST   = 2'h0;
    localparam logic [6:0]  WIN_LOW_LIMIT = 7'h40;
    localparam logic [6:0]  WIN_WARN_PRE  = 7'h41;
    localparam int          WIN_BASE_DIV  = 4096;
    localparam int          WIN_DIV_STEPS = 8;
    // ==============================================================
    // timing: low-speed clock and shortest independent timeout
    localparam int CLK_PERIOD_NS      = 10;
    localparam int LSI_FREQ_HZ        = 32000;
    localparam int IND_MIN_TIMEOUT_NS = 125000;
    localparam int IND_MIN_TIMEOUT_LSI =
        (IND_MIN_TIMEOUT_NS * (LSI_FREQ_HZ / 1000) + 999999) / 1000000;
    localparam int IND_MIN_DIV = 4;
    localparam int IND_MAX_DIV = 256;
endpackage

module dwdt_indep (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        lsi_tick,
    input  wire logic        auto_start,
    input  wire logic        dbg_halt,
    input  wire logic        dbg_freeze,
    input  wire logic        key_wr,
    input  wire logic [15:0] key_data,
    input  wire logic        psc_wr,
    input  wire logic [2:0]  psc_data,
    input  wire logic        rld_wr,
    input  wire logic [11:0] rld_data,
    input  wire logic        rst_ack,
    output logic [2:0]       indep_prescale_reg,
    output logic [11:0]      indep_reload_reg,
    output logic             prescale_update_flag,
    output logic             reload_update_flag,
    output logic             unlocked,
    output logic             running,
    output logic [11:0]      count,
    output logic             rst_req
);
    // ==============================================================
    // divider lookup: codes 6 and 7 both give the largest step
    function automatic logic [8:0] psc_last(input logic [2:0] code);
        psc_last = (code >= 3'h6) ? 9'h0ff : 9'((9'h004 << code) - 9'h001);
    endfunction

    // shortest timeout must be one step of the smallest divider
    if (dwdt_pkg::IND_MIN_TIMEOUT_LSI != dwdt_pkg::IND_MIN_DIV) begin : g_chk
        $error("shortest timeout does not match smallest divider");
    end

    logic        strap_reg, strap_next, run_reg, run_next, unl_reg, unl_next;
    logic [2:0]  psc_reg, psc_next, psc_act_reg, psc_act_next;
    logic [11:0] rld_reg, rld_next, rld_act_reg, rld_act_next;
    logic        pflag_reg, pflag_next, rflag_reg, rflag_next;
    logic [7:0]  div_reg, div_next;
    logic [11:0] cnt_reg, cnt_next;
    logic        req_reg, req_next, tick_en, cnt_tick, refresh, expire;

    assign refresh  = key_wr && key_data == dwdt_pkg::KEY_REFRESH;
    // frozen only when halted and the freeze option is chosen
    assign tick_en  = lsi_tick && run_reg && !(dbg_halt && dbg_freeze);
    assign cnt_tick = tick_en && {1'b0, div_reg} == psc_last(psc_act_reg);
    assign expire   = cnt_tick && cnt_reg == dwdt_pkg::IND_CNT_ZERO;

    // control, protection and counter next state
    always_comb begin
        strap_next   = 1'b1;
        run_next     = run_reg;
        unl_next     = unl_reg;
        psc_next     = psc_reg;
        rld_next     = rld_reg;
        pflag_next   = pflag_reg && !lsi_tick;
        rflag_next   = rflag_reg && !lsi_tick;
        psc_act_next = (pflag_reg && lsi_tick) ? psc_reg : psc_act_reg;
        rld_act_next = (rflag_reg && lsi_tick) ? rld_reg : rld_act_reg;
        div_next     = tick_en ? (cnt_tick ? 8'h00 : 8'(div_reg + 8'h01)) : div_reg;
        cnt_next     = cnt_reg;
        // strap is caught in the first cycle after reset release
        if (!strap_reg && auto_start)
            run_next = 1'b1;
        if (key_wr && key_data == dwdt_pkg::KEY_START)
            run_next = 1'b1;
        if (key_wr)
            unl_next = key_data == dwdt_pkg::KEY_UNLOCK;
        if (psc_wr && unl_reg && !pflag_reg) begin
            psc_next   = psc_data;
            pflag_next = 1'b1;
        end
        if (rld_wr && unl_reg && !rflag_reg) begin
            rld_next   = rld_data;
            rflag_next = 1'b1;
        end
        if (refresh) begin
            cnt_next = rld_act_reg;
            div_next = 8'h00;
        end else if (expire) begin
            cnt_next = rld_act_reg;
        end else if (cnt_tick) begin
            cnt_next = 12'(cnt_reg - 12'h001);
        end
        req_next = expire || (req_reg && !rst_ack);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_reg   <= 1'b0;
            run_reg     <= 1'b0;
            unl_reg     <= 1'b0;
            psc_reg     <= dwdt_pkg::PRESCALE_RST;
            psc_act_reg <= dwdt_pkg::PRESCALE_RST;
            rld_reg     <= dwdt_pkg::RELOAD_RST;
            rld_act_reg <= dwdt_pkg::RELOAD_RST;
            pflag_reg   <= 1'b0;
            rflag_reg   <= 1'b0;
            div_reg     <= 8'h00;
            cnt_reg     <= dwdt_pkg::RELOAD_RST;
            req_reg     <= 1'b0;
        end else begin
            strap_reg   <= strap_next;
            run_reg     <= run_next;
            unl_reg     <= unl_next;
            psc_reg     <= psc_next;
            psc_act_reg <= psc_act_next;
            rld_reg     <= rld_next;
            rld_act_reg <= rld_act_next;
            pflag_reg   <= pflag_next;
            rflag_reg   <= rflag_next;
            div_reg     <= div_next;
            cnt_reg     <= cnt_next;
            req_reg     <= req_next;
        end
    end

    assign indep_prescale_reg   = psc_reg;
    assign indep_reload_reg     = rld_reg;
    assign prescale_update_flag = pflag_reg;
    assign reload_update_flag   = rflag_reg;
    assign unlocked             = unl_reg;
    assign running              = run_reg;
    assign count                = cnt_reg;
    assign rst_req              = req_reg;

    // ==============================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_IND_START: assert property (key_wr && key_data == dwdt_pkg::KEY_START |=> running)
        else $error("start code did not enable the watchdog");
    AST_IND_REFRESH: assert property (refresh |=> count == $past(rld_act_reg) && !unlocked)
        else $error("refresh did not reload and relock");
    AST_IND_LOCK: assert property (key_wr && key_data != dwdt_pkg::KEY_UNLOCK |=> !unlocked)
        else $error("protection not restored");
    AST_IND_PROT: assert property (
        rld_wr && (!unlocked || reload_update_flag) |=> $stable(indep_reload_reg))
        else $error("locked reload changed");
    AST_IND_FREEZE: assert property (dbg_halt && dbg_freeze && !refresh |=> $stable(count))
        else $error("counter moved while frozen");
endmodule

`default_nettype wire

// ---- verif/dwdt_top_tb.sv ----
// self-checking testbench for the dual watchdog top
`timescale 1ns/1ps
`default_nettype none

module dwdt_top_tb;
    // ==============================================================
    // signals and design instance
    localparam int WBASE = 16; // short window time base keeps the run brief
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        lsi_tick = 1'b0, auto_start = 1'b0, dbg_halt = 1'b0, dfrz = 1'b0;
    logic        kwr = 1'b0, pwr = 1'b0, rwr = 1'b0, iack = 1'b0;
    logic [15:0] kdat = 16'h0000;
    logic [2:0]  pdat = 3'h0;
    logic [11:0] rdat = 12'h000;
    logic        wcwr = 1'b0, wen = 1'b0, wfwr = 1'b0, wewi = 1'b0;
    logic        wswr = 1'b0, wsdat = 1'b0, wack = 1'b0;
    logic [6:0]  wcdat = 7'h00, wvdat = 7'h00;
    logic [1:0]  wdiv = 2'h0;
    logic [15:0] key_rd;
    logic [2:0]  psc_reg;
    logic [11:0] rld_reg, icnt;
    logic        pflag, rflag, unl, run, irst;
    logic        w_en, w_ewi, w_flag, w_irq, w_rst;
    logic [6:0]  w_cnt, w_val, wprev;
    logic [1:0]  w_div;
    int          errors = 0;
    int          n_compared = 0;
    int          cycles = 0;
    int          k;

    dwdt_top #(.WIN_BASE_DIV(WBASE)) dut (
        .sys_clk(sys_clk), .nrst(nrst), .lsi_tick(lsi_tick), .auto_start(auto_start),
        .dbg_halt(dbg_halt), .debug_freeze_reg(dfrz), .indep_key_wr(kwr),
        .indep_key_data(kdat), .indep_prescale_wr(pwr), .indep_prescale_data(pdat),
        .indep_reload_wr(rwr), .indep_reload_data(rdat), .indep_rst_ack(iack),
        .indep_key_rdata(key_rd), .indep_prescale_reg(psc_reg), .indep_reload_reg(rld_reg),
        .prescale_update_flag(pflag), .reload_update_flag(rflag), .indep_unlocked(unl),
        .indep_running(run), .indep_count(icnt), .indep_rst_req(irst),
        .window_control_wr(wcwr), .window_enable_bit(wen), .window_count_data(wcdat),
        .window_config_wr(wfwr), .window_value_data(wvdat), .window_timebase_div(wdiv),
        .early_warning_int_enable(wewi), .window_status_wr(wswr),
        .window_status_data(wsdat), .window_rst_ack(wack), .window_enabled(w_en),
        .window_count(w_cnt), .window_value(w_val), .window_div(w_div),
        .window_ewi_enabled(w_ewi), .window_status_reg(w_flag), .window_irq(w_irq),
        .window_rst_req(w_rst)
    );

    // ==============================================================
    // clock, hang guard and closing report
    always #5 sys_clk = ~sys_clk;

    // the whole run needs a few thousand cycles, so this only trips on a hang
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            test_done();
        end
    end

    task automatic test_done();
        if (errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // ==============================================================
    // access tasks: strobe for one cycle, look one step after the taking edge
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic key(input logic [15:0] v);
        @(posedge sys_clk) begin kwr <= 1'b1; kdat <= v; end
        @(posedge sys_clk) kwr <= 1'b0;
        #1;
    endtask

    task automatic rld(input logic [11:0] v);
        @(posedge sys_clk) begin rwr <= 1'b1; rdat <= v; end
        @(posedge sys_clk) rwr <= 1'b0;
        #1;
    endtask

    task automatic psc(input logic [2:0] v);
        @(posedge sys_clk) begin pwr <= 1'b1; pdat <= v; end
        @(posedge sys_clk) pwr <= 1'b0;
        #1;
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge sys_clk) lsi_tick <= 1'b1;
            @(posedge sys_clk) lsi_tick <= 1'b0;
        end
        #1;
    endtask

    task automatic wctl(input logic e, input logic [6:0] c);
        @(posedge sys_clk) begin wcwr <= 1'b1; wen <= e; wcdat <= c; end
        @(posedge sys_clk) wcwr <= 1'b0;
        #1;
    endtask

    task automatic wcfg(input logic [6:0] v, input logic [1:0] d, input logic e);
        @(posedge sys_clk) begin wfwr <= 1'b1; wvdat <= v; wdiv <= d; wewi <= e; end
        @(posedge sys_clk) wfwr <= 1'b0;
        #1;
    endtask

    task automatic wsts(input logic d);
        @(posedge sys_clk) begin wswr <= 1'b1; wsdat <= d; end
        @(posedge sys_clk) wswr <= 1'b0;
        #1;
    endtask

    task automatic pulse_ack(input logic win);
        @(posedge sys_clk) begin iack <= !win; wack <= win; end
        @(posedge sys_clk) begin iack <= 1'b0; wack <= 1'b0; end
        #1;
    endtask

    // counts edges until the window count moves, bounded
    task automatic wstep(output int n);
        logic [6:0] old;
        old = w_cnt;
        n = 0;
        while (w_cnt === old && n < 300) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
    endtask

    // ==============================================================
    // main sequence
    initial begin
        cyc(16);
        @(posedge sys_clk) nrst <= 1'b1;
        cyc(3);
        chk(key_rd, 16'h0000, "key reads");
        chk(16'(rld_reg), 16'h0fff, "reload reset");
        chk(16'(w_en), 16'h0000, "window off");
        // independent: unlock, flag-gated reload writes, relock
        key(16'h5555);
        chk(16'(unl), 16'h0001, "unlock");
        rld(12'h005);
        chk(16'(rflag), 16'h0001, "update flag");
        rld(12'h007);
        chk(16'(rld_reg), 16'h0005, "write while busy");
        tick(1);
        key(16'h1234);
        chk(16'(unl), 16'h0000, "relock other key");
        rld(12'h009);
        chk(16'(rld_reg), 16'h0005, "locked write");
        key(16'h5555);
        key(16'haaaa);
        chk(16'(unl), 16'h0000, "relock refresh");
        chk(16'(icnt), 16'h0005, "refresh load");
        key(16'hcccc);
        chk(16'(run), 16'h0001, "started");
        // every prescale code: count holds for divider-1 ticks, drops on the last
        for (int c = 0; c < 8; c++) begin
            k = (c >= 6) ? 256 : (4 << c);
            key(16'h5555);
            psc(3'(c));
            chk(16'({pflag, psc_reg}), 16'({1'b1, 3'(c)}), "prescale write");
            tick(1);
            key(16'haaaa);
            tick(k - 1);
            chk(16'(icnt), 16'h0005, "divider early");
            tick(1);
            chk(16'(icnt), 16'h0004, "divider step");
        end
        key(16'h5555);
        psc(3'h0);
        tick(1);
        key(16'haaaa);
        // debug halt freezes only while the freeze bit is set
        @(posedge sys_clk) begin dbg_halt <= 1'b1; dfrz <= 1'b1; end
        tick(8);
        chk(16'(icnt), 16'h0005, "frozen");
        @(posedge sys_clk) dfrz <= 1'b0;
        tick(4);
        chk(16'(icnt), 16'h0004, "halt not frozen");
        @(posedge sys_clk) dbg_halt <= 1'b0;
        k = 0;
        while (irst !== 1'b1 && k < 40) begin
            tick(1);
            k++;
        end
        chk(16'(irst), 16'h0001, "expiry reset");
        cyc(5);
        chk(16'(irst), 16'h0001, "request held");
        pulse_ack(1'b0);
        chk(16'(irst), 16'h0000, "request acked");
        // window: tick spacing for every time base code, while still disabled
        for (int d = 0; d < 4; d++) begin
            wcfg(7'h7f, 2'(d), 1'b0);
            wstep(k);
            wstep(k);
            chk(16'(k), 16'(WBASE << d), "window period");
        end
        wprev = w_cnt;
        wstep(k);
        chk(16'(w_cnt), 16'(7'(wprev - 7'h01)), "free running");
        chk(16'(w_rst), 16'h0000, "no reset disabled");
        wcfg(7'h50, 2'h0, 1'b1);
        chk(16'({w_val, w_div, w_ewi}), 16'({7'h50, 2'h0, 1'b1}), "window config");
        // enable with the count above the window, then reload too early
        wctl(1'b1, 7'h60);
        chk(16'(w_en), 16'h0001, "enabled");
        wctl(1'b1, 7'h48);
        chk(16'(w_rst), 16'h0001, "early reload");
        pulse_ack(1'b1);
        chk(16'(w_rst), 16'h0000, "window acked");
        wctl(1'b1, 7'h50);
        chk(16'(w_rst), 16'h0000, "reload at window");
        wsts(1'b0);
        wctl(1'b1, 7'h42);
        k = 0;
        while (w_cnt !== 7'h40 && k < 100) begin
            cyc(1);
            k++;
        end
        chk(16'(w_flag), 16'h0001, "warning flag");
        chk(16'(w_irq), 16'h0001, "warning irq");
        wsts(1'b1);
        chk(16'(w_flag), 16'h0001, "write one keeps");
        wsts(1'b0);
        chk(16'(w_flag), 16'h0000, "write zero clears");
        k = 0;
        while (w_rst !== 1'b1 && k < 100) begin
            cyc(1);
            k++;
        end
        chk(16'(w_rst), 16'h0001, "underflow reset");
        chk(16'(w_cnt), 16'h003f, "underflow count");
        pulse_ack(1'b1);
        // second reset with the automatic-start strap set
        @(posedge sys_clk) begin nrst <= 1'b0; auto_start <= 1'b1; end
        cyc(4);
        @(posedge sys_clk) nrst <= 1'b1;
        cyc(4);
        chk(16'(run), 16'h0001, "auto start");
        test_done();
    end
endmodule
`default_nettype wire
